// [design/increment_conditional_skip_exec.v]
/*
 * Execution of the two increment-and-skip byte instructions, one phase per clock.
 * Assumes the fetch unit presents one instruction word with instr_valid while
 * ready_q is high, and the register file answers a read in the same cycle.
 */
`timescale 1ns/10ps
`include "incskip_defines.vh"

module increment_conditional_skip_exec #(
    parameter AW = 12
) (
    input  wire          core_clk,
    input  wire          rst_n,
    input  wire          instr_valid,
    input  wire [15:0]   instr_word,
    input  wire          next_is_two_word,
    input  wire          ext_set_en,
    input  wire [3:0]    bank_select_register,
    input  wire [AW-1:0] index_base,
    input  wire [7:0]    rf_rd_data,
    output reg           ready_q,
    output reg           accepted_q,
    output reg  [1:0]    phase_q,
    output reg           nop_cycle_q,
    output reg  [AW-1:0] rf_addr_q,
    output reg           indexed_mode_q,
    output reg           rf_rd_en_q,
    output reg           rf_wr_en_q,
    output reg  [7:0]    rf_wr_data_q,
    output reg           working_register_wr_en_q,
    output reg  [7:0]    working_register_wr_data_q,
    output reg           skip_q,
    output reg           done_q,
    output reg           status_wr_en_q
);

    // ======================================================================
    // Decode helpers
    // ======================================================================
    function is_skip_nz;
        input [15:0] w;
        begin
            is_skip_nz = (w[`OPC_HI_MSB:`OPC_HI_LSB] == `OPC_SKIP_NZ);
        end
    endfunction

    function is_skip_z;
        input [15:0] w;
        begin
            is_skip_z = (w[`OPC_HI_MSB:`OPC_HI_LSB] == `OPC_SKIP_Z);
        end
    endfunction

    // Skip sense differs only by polarity of the zero test
    function skip_decide;
        input       nz_op;
        input [7:0] res;
        begin
            if (nz_op) begin
                skip_decide = (res != 8'h00);
            end else begin
                skip_decide = (res == 8'h00);
            end
        end
    endfunction

    // ======================================================================
    // State
    // ======================================================================
    reg [1:0]    st_q;
    reg          op_nz_q;
    reg          dest_q;
    reg [7:0]    result_q;
    reg          two_word_q;
    reg          nop_left_q;
    reg          take_skip_q;

    wire [AW-1:0] addr_w;
    wire          idx_w;
    wire          start_w;
    wire [7:0]    sum_w;

    // ======================================================================
    // Operand resolution
    // ======================================================================
    // Resolved address is latched at decode, so bank or pointer changes
    // during the later phases cannot move the write-back target
    file_addr_resolve #(
        .AW (AW)
    ) u_addr (
        .file_address         (instr_word[`OPC_FILE_MSB:`OPC_FILE_LSB]),
        .access_select        (instr_word[`OPC_ACC_BIT]),
        .ext_set_en           (ext_set_en),
        .bank_select_register (bank_select_register),
        .index_base           (index_base),
        .data_address         (addr_w),
        .indexed_mode         (idx_w)
    );

    // ======================================================================
    // Take and increment
    // ======================================================================
    // Read data must stand at the edge that ends Q2; no wait state exists
    // Other opcodes are simply not taken; the core routes them elsewhere
    assign start_w = ready_q && instr_valid &&
                     (is_skip_nz(instr_word) || is_skip_z(instr_word));
    assign sum_w   = rf_rd_data + 8'h01;

    // ======================================================================
    // Sequencer
    // ======================================================================
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q                       <= `ST_IDLE;
            phase_q                    <= `PH_Q1;
            ready_q                    <= 1'b0;
            accepted_q                 <= 1'b0;
            nop_cycle_q                <= 1'b0;
            rf_addr_q                  <= {AW{1'b0}};
            indexed_mode_q             <= 1'b0;
            rf_rd_en_q                 <= 1'b0;
            rf_wr_en_q                 <= 1'b0;
            rf_wr_data_q               <= 8'h00;
            working_register_wr_en_q   <= 1'b0;
            working_register_wr_data_q <= 8'h00;
            skip_q                     <= 1'b0;
            done_q                     <= 1'b0;
            status_wr_en_q             <= 1'b0;
            op_nz_q                    <= 1'b0;
            dest_q                     <= 1'b0;
            result_q                   <= 8'h00;
            two_word_q                 <= 1'b0;
            nop_left_q                 <= 1'b0;
            take_skip_q                <= 1'b0;
        end else begin
            accepted_q               <= 1'b0;
            rf_wr_en_q               <= 1'b0;
            working_register_wr_en_q <= 1'b0;
            skip_q                   <= 1'b0;
            done_q                   <= 1'b0;
            rf_rd_en_q               <= 1'b0;
            // Flags are never touched; held low so the core keeps them
            status_wr_en_q           <= 1'b0;
            case (st_q)
                `ST_IDLE: begin
                    ready_q <= 1'b1;
                    phase_q <= `PH_Q1;
                    if (start_w) begin
                        // Q1: decode and latch the resolved operand
                        st_q           <= `ST_EXEC;
                        ready_q        <= 1'b0;
                        accepted_q     <= 1'b1;
                        phase_q        <= `PH_Q2;
                        op_nz_q        <= is_skip_nz(instr_word);
                        dest_q         <= instr_word[`OPC_DEST_BIT];
                        two_word_q     <= next_is_two_word;
                        rf_addr_q      <= addr_w;
                        indexed_mode_q <= idx_w;
                        rf_rd_en_q     <= 1'b1;
                    end
                end
                `ST_EXEC: begin
                    case (phase_q)
                        `PH_Q2: begin
                            // Read data is sampled at the end of Q2
                            result_q <= sum_w;
                            phase_q  <= `PH_Q3;
                        end
                        `PH_Q3: begin
                            take_skip_q <= skip_decide(op_nz_q, result_q);
                            phase_q <= `PH_Q4;
                        end
                        `PH_Q4: begin
                            if (dest_q) begin
                                rf_wr_en_q   <= 1'b1;
                                rf_wr_data_q <= result_q;
                            end else begin
                                working_register_wr_en_q   <= 1'b1;
                                working_register_wr_data_q <= result_q;
                            end
                            phase_q <= `PH_Q1;
                            if (take_skip_q) begin
                                // Fetched word is dropped; no-op cycles replace it
                                skip_q      <= 1'b1;
                                st_q        <= `ST_NOP;
                                nop_cycle_q <= 1'b1;
                                nop_left_q  <= two_word_q;
                            end else begin
                                st_q    <= `ST_IDLE;
                                done_q  <= 1'b1;
                                ready_q <= 1'b1;
                            end
                        end
                        default: begin
                            phase_q <= `PH_Q1;
                            st_q    <= `ST_IDLE;
                        end
                    endcase
                end
                `ST_NOP: begin
                    // Each no-op spans a full four-phase cycle
                    phase_q <= phase_q + 2'h1;
                    if (phase_q == `PH_Q4) begin
                        if (nop_left_q) begin
                            nop_left_q <= 1'b0;
                        end else begin
                            st_q        <= `ST_IDLE;
                            nop_cycle_q <= 1'b0;
                            done_q      <= 1'b1;
                            ready_q     <= 1'b1;
                        end
                    end
                end
                default: begin
                    st_q    <= `ST_IDLE;
                    phase_q <= `PH_Q1;
                end
            endcase
        end
    end

endmodule // increment_conditional_skip_exec

// [design/incskip_defines.vh]
/*
 * Constants for the increment-and-skip execution block.
 * Assumes inclusion by bare name from the design files; definitions only.
 */
// What this block does
// - Recognise skip-if-nonzero opcode 0100_10da_ffff_ffff
// - Add one, test result against zero
// - Destination bit picks working register or file
// - Nonzero result discards next, one no-op cycle
// - Two-word next gives two no-ops; else one
// - Access bit picks access bank or bank register
// - Extended set, access 0, f<=95: indexed literal offset
// - Four phases: decode, read, process, write
// - Skip-if-zero variant skips only on zero result
`ifndef INCSKIP_DEFINES_VH
`define INCSKIP_DEFINES_VH

// ==========================================================================
// Opcode fields
// ==========================================================================
`define OPC_HI_MSB        15
`define OPC_HI_LSB        10
`define OPC_SKIP_NZ       6'h12
`define OPC_SKIP_Z        6'h0F
`define OPC_DEST_BIT      9
`define OPC_ACC_BIT       8
`define OPC_FILE_MSB      7
`define OPC_FILE_LSB      0

// ==========================================================================
// Addressing
// ==========================================================================
`define ACC_SPLIT         8'h60
`define ILO_LIMIT         8'h5F
`define ACC_HI_BANK       4'hF
`define ACC_LO_BANK       4'h0

// ==========================================================================
// Sequencer
// ==========================================================================
`define PH_Q1             2'h0
`define PH_Q2             2'h1
`define PH_Q3             2'h2
`define PH_Q4             2'h3
`define ST_IDLE           2'h0
`define ST_EXEC           2'h1
`define ST_NOP            2'h2

`endif

// [design/file_addr_resolve.v]
/*
 * Combinational operand address resolution for byte-oriented file access.
 * Assumes bank register and indirect pointer are stable while decoding.
 */
`timescale 1ns/10ps
`include "incskip_defines.vh"

module file_addr_resolve #(
    parameter AW = 12
) (
    input  wire [7:0]    file_address,
    input  wire          access_select,
    input  wire          ext_set_en,
    input  wire [3:0]    bank_select_register,
    input  wire [AW-1:0] index_base,
    output reg  [AW-1:0] data_address,
    output reg           indexed_mode
);

    // ======================================================================
    // Address selection
    // ======================================================================
    always @* begin
        indexed_mode = 1'b0;
        if (access_select) begin
            data_address = {bank_select_register, file_address};
        end else if (ext_set_en && (file_address <= `ILO_LIMIT)) begin
            // Offset wraps in the data space, matching pointer arithmetic
            data_address = index_base + {{(AW-8){1'b0}}, file_address};
            indexed_mode = 1'b1;
        end else if (file_address < `ACC_SPLIT) begin
            data_address = {`ACC_LO_BANK, file_address};
        end else begin
            data_address = {`ACC_HI_BANK, file_address};
        end
    end

endmodule // file_addr_resolve

// [sim/incskip_props.sv]
/*
 * Checker for the increment-and-skip execution block.
 * Assumes it is bound to the block's top module and sees only its ports.
 */
`timescale 1ns/10ps
`include "incskip_defines.vh"
module incskip_props #(
    parameter AW = 12
) (
    input wire          core_clk,
    input wire          rst_n,
    input wire          instr_valid,
    input wire [15:0]   instr_word,
    input wire          next_is_two_word,
    input wire          ext_set_en,
    input wire [3:0]    bank_select_register,
    input wire [AW-1:0] index_base,
    input wire [7:0]    rf_rd_data,
    input wire          ready_q,
    input wire          accepted_q,
    input wire [1:0]    phase_q,
    input wire          nop_cycle_q,
    input wire [AW-1:0] rf_addr_q,
    input wire          indexed_mode_q,
    input wire          rf_rd_en_q,
    input wire          rf_wr_en_q,
    input wire [7:0]    rf_wr_data_q,
    input wire          working_register_wr_en_q,
    input wire [7:0]    working_register_wr_data_q,
    input wire          skip_q,
    input wire          done_q,
    input wire          status_wr_en_q
);
    // ======================================================================
    // Helper logic
    // ======================================================================
    reg        op_nz_q;
    reg        dest_q;
    reg        two_q;
    wire       wr = rf_wr_en_q || working_register_wr_en_q;
    wire [7:0] wr_val = rf_wr_en_q ? rf_wr_data_q : working_register_wr_data_q;
    wire       ours = instr_word[15:10] == `OPC_SKIP_NZ || instr_word[15:10] == `OPC_SKIP_Z;

    // Latched only while idle, so a refused word cannot disturb a running one
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            op_nz_q <= 1'b0;
            dest_q <= 1'b0;
            two_q <= 1'b0;
        end else if (ready_q && instr_valid) begin
            op_nz_q <= instr_word[15:10] == `OPC_SKIP_NZ;
            dest_q <= instr_word[9];
            two_q <= next_is_two_word;
        end
    end

    function [AW-1:0] exp_addr(input [15:0] w, input ex, input [3:0] bs, input [AW-1:0] b);
        if (ex && !w[8] && w[7:0] <= 8'h5F) exp_addr = b + w[7:0];
        else if (w[8]) exp_addr = {bs, w[7:0]};
        else exp_addr = {(w[7:0] < 8'h60) ? 4'h0 : 4'hF, w[7:0]};
    endfunction

    // ======================================================================
    // Assertions
    // ======================================================================
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    take_decode_a: assert property (
        ready_q && instr_valid && ours |=> accepted_q && rf_rd_en_q && !ready_q)
        else $error("opcode not taken");
    refuse_other_a: assert property (
        ready_q && instr_valid && !ours |=> !accepted_q && ready_q)
        else $error("foreign opcode taken");
    phase_seq_a: assert property (
        accepted_q |-> phase_q == `PH_Q2 ##1 phase_q == `PH_Q3 ##1 phase_q == `PH_Q4
        ##1 (phase_q == `PH_Q1 && wr)) else $error("phase order wrong");
    incr_value_a: assert property (
        wr |-> wr_val == $past(rf_rd_data, 3) + 8'h01) else $error("bad increment");
    dest_pick_a: assert property (
        wr |-> rf_wr_en_q == dest_q && rf_wr_en_q != working_register_wr_en_q)
        else $error("wrong destination");
    skip_cond_a: assert property (
        wr |-> skip_q == (op_nz_q ? wr_val != 8'h00 : wr_val == 8'h00))
        else $error("skip decision wrong");
    noskip_done_a: assert property (
        wr && !skip_q |-> done_q && ready_q) else $error("no-skip not one cycle");
    skip_nop_a: assert property (
        skip_q |-> !done_q ##1 nop_cycle_q [*3] ##1 (done_q != two_q))
        else $error("no-op cycle wrong");
    two_word_a: assert property (
        skip_q && two_q |-> ##8 done_q) else $error("two no-ops missing");
    addr_mode_a: assert property (
        accepted_q |-> rf_addr_q == exp_addr($past(instr_word), $past(ext_set_en),
        $past(bank_select_register), $past(index_base))) else $error("bad address");
    status_hold_a: assert property (
        !status_wr_en_q) else $error("status written");

    cover property (skip_q && two_q);
    cover property (wr && !skip_q);
    cover property (accepted_q && indexed_mode_q);
endmodule // incskip_props

bind increment_conditional_skip_exec incskip_props #(.AW(AW)) u_props (
    .core_clk(core_clk), .rst_n(rst_n), .instr_valid(instr_valid),
    .instr_word(instr_word), .next_is_two_word(next_is_two_word),
    .ext_set_en(ext_set_en), .bank_select_register(bank_select_register),
    .index_base(index_base), .rf_rd_data(rf_rd_data), .ready_q(ready_q),
    .accepted_q(accepted_q), .phase_q(phase_q), .nop_cycle_q(nop_cycle_q),
    .rf_addr_q(rf_addr_q), .indexed_mode_q(indexed_mode_q), .rf_rd_en_q(rf_rd_en_q),
    .rf_wr_en_q(rf_wr_en_q), .rf_wr_data_q(rf_wr_data_q),
    .working_register_wr_en_q(working_register_wr_en_q),
    .working_register_wr_data_q(working_register_wr_data_q),
    .skip_q(skip_q), .done_q(done_q), .status_wr_en_q(status_wr_en_q));

// [sim/testbench.sv]
/*
 * Self-checking bench for the increment-and-skip block.
 * Assumes the bench plays fetch unit and register file itself.
 */
`timescale 1ns/10ps
module testbench;
    reg         core_clk;
    reg         rst_n;
    reg         instr_valid;
    reg [15:0]  instr_word;
    reg         two_word;
    reg         ext_set_en;
    reg [3:0]   bank_sel;
    reg [11:0]  index_base;
    reg [7:0]   rf_rd_data;
    wire        ready_q, accepted_q, indexed_mode_q, rf_wr_en_q, w_en, skip_q, done_q, st_q;
    wire        rd_en, nop_c;
    wire [1:0]  phase;
    wire [11:0] rf_addr_q;
    wire [7:0]  rf_wr_data_q, w_data;
    integer     mismatches, checked, cycles;

    increment_conditional_skip_exec #(.AW(12)) uut (
        .core_clk(core_clk), .rst_n(rst_n), .instr_valid(instr_valid),
        .instr_word(instr_word), .next_is_two_word(two_word), .ext_set_en(ext_set_en),
        .bank_select_register(bank_sel), .index_base(index_base), .rf_rd_data(rf_rd_data),
        .ready_q(ready_q), .accepted_q(accepted_q), .phase_q(phase), .nop_cycle_q(nop_c),
        .rf_addr_q(rf_addr_q), .indexed_mode_q(indexed_mode_q), .rf_rd_en_q(rd_en),
        .rf_wr_en_q(rf_wr_en_q), .rf_wr_data_q(rf_wr_data_q),
        .working_register_wr_en_q(w_en), .working_register_wr_data_q(w_data),
        .skip_q(skip_q), .done_q(done_q), .status_wr_en_q(st_q));

    // ======================================================================
    // Shared tasks
    // ======================================================================
    task chk(input [15:0] got, input [15:0] exp);
        begin
            checked = checked + 1;
            if (got !== exp) begin
                mismatches = mismatches + 1;
                $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask

    task give_verdict;
        begin
            $display("checks %0d, mismatches %0d", checked, mismatches);
            if (mismatches == 0 && checked > 0) $display("TB: PASS");
            else $display("TB: FAIL");
            $finish;
        end
    endtask

    // One instruction; edone counts edges from the take, the take edge being 1
    task issue(input [5:0] op, input d, input a, input [7:0] f, input [7:0] rd, input tw,
               input ex, input [3:0] bs, input [11:0] b, input [11:0] ea, input ei,
               input [15:0] edone);
        reg [15:0] n;
        reg [15:0] dn;
        reg [7:0]  inc;
        begin
            // Eight-bit sum, so a wrap to zero is expected as zero
            inc = rd + 8'h01;
            while (ready_q !== 1'b1) @(posedge core_clk) #1;
            @(posedge core_clk);
            instr_valid <= 1'b1;
            instr_word <= {op, d, a, f};
            two_word <= tw;
            ext_set_en <= ex;
            bank_sel <= bs;
            index_base <= b;
            rf_rd_data <= rd;
            @(posedge core_clk);
            instr_valid <= 1'b0;
            #1;
            chk(accepted_q, 1'b1);
            chk(rd_en, 1'b1);
            chk(phase, 2'h1);
            n = 1;
            dn = 0;
            while (dn == 0 && n < 14) begin
                @(posedge core_clk) #1;
                n = n + 1;
                if (rf_wr_en_q === 1'b1 || w_en === 1'b1) begin
                    chk(n, 16'd4);
                    chk(rf_wr_en_q, d);
                    chk(rf_wr_en_q ? rf_wr_data_q : w_data, inc);
                    chk(skip_q, edone != 16'd4);
                    chk(nop_c, edone != 16'd4);
                end
                if (done_q === 1'b1) dn = n;
            end
            chk(dn, edone);
            chk(nop_c, 1'b0);
            chk(rf_addr_q, ea);
            chk(indexed_mode_q, ei);
            chk(st_q, 1'b0);
        end
    endtask

    // ======================================================================
    // Scenarios
    // ======================================================================
    task t_nz_skip;
        begin
            issue(6'h12, 1, 0, 8'h20, 8'h41, 0, 0, 4'h0, 12'h000, 12'h020, 0, 16'd8);
            issue(6'h12, 0, 1, 8'h80, 8'hFF, 1, 0, 4'h5, 12'h000, 12'h580, 0, 16'd4);
            $display("test nz_skip done");
        end
    endtask

    task t_two_word;
        begin
            issue(6'h12, 1, 0, 8'h60, 8'h00, 1, 0, 4'h3, 12'h000, 12'hF60, 0, 16'd12);
            $display("test two_word done");
        end
    endtask

    task t_zero_skip;
        begin
            issue(6'h0F, 1, 0, 8'h10, 8'hFF, 1, 0, 4'h0, 12'h000, 12'h010, 0, 16'd12);
            issue(6'h0F, 0, 1, 8'h10, 8'h10, 0, 0, 4'hA, 12'h000, 12'hA10, 0, 16'd4);
            $display("test zero_skip done");
        end
    endtask

    task t_indexed;
        begin
            issue(6'h12, 1, 0, 8'h5F, 8'h07, 0, 1, 4'h0, 12'hFF0, 12'h04F, 1, 16'd8);
            issue(6'h12, 1, 0, 8'h60, 8'h07, 0, 1, 4'h0, 12'hFF0, 12'hF60, 0, 16'd8);
            issue(6'h12, 1, 1, 8'h05, 8'h07, 0, 1, 4'h2, 12'hFF0, 12'h205, 0, 16'd8);
            $display("test indexed done");
        end
    endtask

    // A plain increment word must leave the block idle
    task t_refuse;
        begin
            @(posedge core_clk);
            instr_valid <= 1'b1;
            instr_word <= 16'h2A20;
            repeat (3) @(posedge core_clk);
            #1;
            chk(ready_q, 1'b1);
            chk(accepted_q, 1'b0);
            @(posedge core_clk);
            instr_valid <= 1'b0;
            $display("test refuse done");
        end
    endtask

    // ======================================================================
    // Clock, timeout and main sequence
    // ======================================================================
    always #5 core_clk = ~core_clk;

    always @(posedge core_clk) begin
        cycles = cycles + 1;
        if (cycles == 600) begin
            mismatches = mismatches + 1;
            give_verdict;
        end
    end

    initial begin
        core_clk = 1'b0;
        rst_n = 1'b0;
        instr_valid = 1'b0;
        instr_word = 16'h0000;
        two_word = 1'b0;
        ext_set_en = 1'b0;
        bank_sel = 4'h0;
        index_base = 12'h000;
        rf_rd_data = 8'h00;
        mismatches = 0;
        checked = 0;
        cycles = 0;
        repeat (3) @(posedge core_clk);
        rst_n <= 1'b1;
        t_refuse;
        t_nz_skip;
        t_two_word;
        t_zero_skip;
        t_indexed;
        give_verdict;
    end
endmodule // testbench
